// [mcp_pkg.sv]
// Constants, types and register map of the motion command/parameter block
package mcp_pkg;

    // Clock and command acceptance timing
    localparam int CLK_PERIOD_NS  = 50;
    localparam int CMD_ACCEPT_NS  = 125;
    localparam int ACCEPT_CYC_RAW = CMD_ACCEPT_NS / CLK_PERIOD_NS;
    localparam int ACCEPT_CYC     = (ACCEPT_CYC_RAW < 1) ? 1 : ACCEPT_CYC_RAW;

    // Register word indices on the plain register port
    localparam logic [2:0] ADDR_CMD    = 3'h0;
    localparam logic [2:0] ADDR_DLO    = 3'h1;
    localparam logic [2:0] ADDR_DHI    = 3'h2;
    localparam logic [2:0] ADDR_MODE3  = 3'h3;
    localparam logic [2:0] ADDR_STATUS = 3'h4;
    localparam logic [2:0] ADDR_RDLO   = 3'h5;
    localparam logic [2:0] ADDR_RDHI   = 3'h6;

    // Field positions
    localparam int CMDW_CODE_LSB = 0;
    localparam int CMDW_AXIS_LSB = 8;
    localparam int MODE3_SYM_BIT = 1;
    localparam int ST_BUSY_BIT   = 0;
    localparam int ST_BAD_BIT    = 1;
    localparam int ST_PAGE_BIT   = 2;
    localparam int ST_HOLD_BIT   = 3;
    localparam int ST_IDEC_BIT   = 4;

    // Reset values
    localparam logic [15:0] WORD_RST  = 16'h0000;
    localparam logic [31:0] PARAM_RST = 32'h0000_0000;

    // Command codes handled here
    localparam logic [7:0] OP_JERK     = 8'h00;
    localparam logic [7:0] OP_DJERK    = 8'h01;
    localparam logic [7:0] OP_ACCEL    = 8'h02;
    localparam logic [7:0] OP_DECEL    = 8'h03;
    localparam logic [7:0] OP_SPEED    = 8'h04;
    localparam logic [7:0] OP_WPAR_END = 8'h19;
    localparam logic [7:0] OP_NOP      = 8'h1F;
    localparam logic [7:0] OP_WMOD_LO  = 8'h20;
    localparam logic [7:0] OP_WMOD_HI  = 8'h2B;
    localparam logic [7:0] OP_RD_LO    = 8'h30;
    localparam logic [7:0] OP_RD_MID1  = 8'h39;
    localparam logic [7:0] OP_RD_MID2  = 8'h3D;
    localparam logic [7:0] OP_RD_HI    = 8'h49;
    localparam logic [7:0] OP_RD_CURAC = 8'h33;
    localparam logic [7:0] OP_RD_ACCEL = 8'h43;
    localparam logic [7:0] OP_RD_SPEED = 8'h44;
    localparam logic [7:0] OP_OTH_LO   = 8'h70;
    localparam logic [7:0] OP_OTH_HI   = 8'h7C;
    localparam logic [7:0] OP_HOLD     = 8'h77;
    localparam logic [7:0] OP_RELEASE  = 8'h78;
    localparam logic [7:0] OP_PAGE0    = 8'h7A;
    localparam logic [7:0] OP_PAGE1    = 8'h7B;
    localparam logic [7:0] OP_DEC_EN   = 8'h6D;
    localparam logic [7:0] OP_DEC_DIS  = 8'h6E;
    localparam logic [7:0] OP_CMD_RST  = 8'hFF;
    localparam logic [3:0] SYNC_EN_HI  = 4'h8;
    localparam logic [3:0] SYNC_DIS_HI = 4'h9;
    localparam logic [3:0] SYNC_ACT_HI = 4'hA;

    // Command classes
    typedef enum logic [3:0] {
        CLS_NONE     = 4'h0,
        CLS_PARAM    = 4'h1,
        CLS_FOREIGN  = 4'h2,
        CLS_READ     = 4'h3,
        CLS_DRIVE    = 4'h4,
        CLS_INTERP   = 4'h5,
        CLS_OTHER    = 4'h6,
        CLS_SYNC_EN  = 4'h7,
        CLS_SYNC_DIS = 4'h8,
        CLS_SYNC_ACT = 4'h9,
        CLS_NOP      = 4'hA,
        CLS_BAD      = 4'hB
    } mcp_cls_t;

    // Command sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01
    } mcp_state_t;

endpackage : mcp_pkg

// [mcp_exec_if.sv]
// Executed command carrier between sequencer, decoder and axis stores
`timescale 1ns/100ps
interface mcp_exec_if;
    logic                exec_stb;
    logic [7:0]          code;
    logic [1:0]          axes;
    logic [31:0]         data;
    mcp_pkg::mcp_cls_t   cls;

    modport ctrl  (output exec_stb, code, axes, data, input cls);
    modport dec   (input code, output cls);
    modport store (input exec_stb, code, axes, data, cls);
endinterface : mcp_exec_if

// [mcp_cmd_decode.sv]
// Command code classifier
`timescale 1ns/100ps
module mcp_cmd_decode (
    mcp_exec_if.dec dec_if
);

    // Map one code onto its command class
    function automatic mcp_pkg::mcp_cls_t mcp_classify(input logic [7:0] c);
        if (c <= mcp_pkg::OP_SPEED)
            mcp_classify = mcp_pkg::CLS_PARAM;
        else if (c <= mcp_pkg::OP_WPAR_END)
            mcp_classify = mcp_pkg::CLS_FOREIGN;
        else if (c == mcp_pkg::OP_NOP)
            mcp_classify = mcp_pkg::CLS_NOP;
        else if (c >= mcp_pkg::OP_WMOD_LO && c <= mcp_pkg::OP_WMOD_HI)
            mcp_classify = mcp_pkg::CLS_FOREIGN;
        else if ((c >= mcp_pkg::OP_RD_LO && c <= mcp_pkg::OP_RD_MID1) ||
                 (c >= mcp_pkg::OP_RD_MID2 && c <= mcp_pkg::OP_RD_HI))
            mcp_classify = mcp_pkg::CLS_READ;
        else if (c inside {[8'h50:8'h54], [8'h56:8'h5A]})
            mcp_classify = mcp_pkg::CLS_DRIVE;
        else if (c inside {8'h61, [8'h64:8'h66], [8'h6D:8'h6F]})
            mcp_classify = mcp_pkg::CLS_INTERP;
        else if (c >= mcp_pkg::OP_OTH_LO && c <= mcp_pkg::OP_OTH_HI)
            mcp_classify = mcp_pkg::CLS_OTHER;
        else if (c[3:0] != 4'h0 && c[7:4] == mcp_pkg::SYNC_EN_HI)
            mcp_classify = mcp_pkg::CLS_SYNC_EN;
        else if (c[3:0] != 4'h0 && c[7:4] == mcp_pkg::SYNC_DIS_HI)
            mcp_classify = mcp_pkg::CLS_SYNC_DIS;
        else if (c[3:0] != 4'h0 && c[7:4] == mcp_pkg::SYNC_ACT_HI)
            mcp_classify = mcp_pkg::CLS_SYNC_ACT;
        else if (c == mcp_pkg::OP_CMD_RST)
            mcp_classify = mcp_pkg::CLS_OTHER;
        else
            mcp_classify = mcp_pkg::CLS_BAD;
    endfunction : mcp_classify

    // Class of the code on the carrier
    assign dec_if.cls = mcp_classify(dec_if.code);

endmodule : mcp_cmd_decode

// [mcp_axis_params.sv]
// Motion parameter store of one axis
`timescale 1ns/100ps
module mcp_axis_params #(
    parameter int AXIS = 0
) (
    input  logic              clock_in,
    input  logic              rst_in,
    mcp_exec_if.store         ex_if,
    input  logic              sym_sel_in,
    output logic [31:0]       jerk_value_out,
    output logic [31:0]       decel_jerk_out,
    output logic [31:0]       accel_rate_out,
    output logic [31:0]       decel_rate_out,
    output logic [31:0]       start_speed_out
);

    logic [31:0] dj_store_q;
    logic [31:0] dc_store_q;
    wire         load_w = ex_if.exec_stb && ex_if.axes[AXIS] &&
                          ex_if.cls == mcp_pkg::CLS_PARAM;

    // Parameter loads, same data into every selected axis
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            jerk_value_out  <= mcp_pkg::PARAM_RST;
            dj_store_q      <= mcp_pkg::PARAM_RST;
            accel_rate_out  <= mcp_pkg::PARAM_RST;
            dc_store_q      <= mcp_pkg::PARAM_RST;
            start_speed_out <= mcp_pkg::PARAM_RST;
        end
        else if (load_w)
        begin
            case (ex_if.code)
                mcp_pkg::OP_JERK:  jerk_value_out  <= ex_if.data;
                mcp_pkg::OP_DJERK: dj_store_q      <= ex_if.data;
                mcp_pkg::OP_ACCEL: accel_rate_out  <= ex_if.data;
                mcp_pkg::OP_DECEL: dc_store_q      <= ex_if.data;
                mcp_pkg::OP_SPEED: start_speed_out <= ex_if.data;
                default:           dj_store_q      <= dj_store_q;
            endcase
        end
    end

    // Effective deceleration values follow the symmetry select bit
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            decel_jerk_out <= mcp_pkg::PARAM_RST;
            decel_rate_out <= mcp_pkg::PARAM_RST;
        end
        else
        begin
            decel_jerk_out <= sym_sel_in ? dj_store_q : jerk_value_out;
            decel_rate_out <= sym_sel_in ? dc_store_q : accel_rate_out;
        end
    end

endmodule : mcp_axis_params

// [mcp_cmd_core.sv]
// Command word decoder and motion parameter write path, two axes
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module mcp_cmd_core (
    input  logic                    clock_in,
    input  logic                    rst_in,
    input  logic [2:0]              reg_addr_in,
    input  logic [15:0]             reg_wdata_in,
    input  logic                    reg_wr_in,
    input  logic                    reg_rd_in,
    output logic [15:0]             reg_rdata_out,
    input  logic [1:0][31:0]        cur_accel_in,
    output logic [1:0][31:0]        jerk_value_out,
    output logic [1:0][31:0]        decel_jerk_value_out,
    output logic [1:0][31:0]        accel_rate_out,
    output logic [1:0][31:0]        decel_rate_out,
    output logic [1:0][31:0]        start_speed_out,
    output logic                    cmd_stb_out,
    output logic [7:0]              cmd_code_out,
    output logic [1:0]              cmd_axes_out,
    output logic [3:0]              cmd_class_out,
    output logic [3:0]              sync_sel_out,
    output logic                    status_page_out,
    output logic                    drive_hold_out,
    output logic                    interp_decel_en_out
);

    mcp_pkg::mcp_state_t state_q;
    mcp_pkg::mcp_state_t state_d;
    logic [15:0]         data_low_word_q;
    logic [15:0]         data_high_word_q;
    logic [15:0]         mode_word_three_q;
    logic [7:0]          code_q;
    logic [1:0]          axes_q;
    logic [31:0]         snap_q;
    logic                bad_q;
    logic [15:0]         rd_lo_q;
    logic [15:0]         rd_hi_q;
    logic [31:0]         rd_sel_w;
    logic [15:0]         rd_mux_w;
    logic [15:0]         status_w;

    mcp_exec_if ex();

    // Register port strobes
    wire wr_cmd_w   = reg_wr_in && reg_addr_in == mcp_pkg::ADDR_CMD;
    wire wr_dlo_w   = reg_wr_in && reg_addr_in == mcp_pkg::ADDR_DLO;
    wire wr_dhi_w   = reg_wr_in && reg_addr_in == mcp_pkg::ADDR_DHI;
    wire wr_mode_w  = reg_wr_in && reg_addr_in == mcp_pkg::ADDR_MODE3;
    wire wr_st_w    = reg_wr_in && reg_addr_in == mcp_pkg::ADDR_STATUS;
    wire idle_w     = state_q == mcp_pkg::ST_IDLE;
    wire take_w     = wr_cmd_w && idle_w;
    wire exec_w     = state_q == mcp_pkg::ST_EXEC;
    wire sym_w      = mode_word_three_q[mcp_pkg::MODE3_SYM_BIT];

    // Executed command onto the carrier
    assign ex.exec_stb = exec_w;
    assign ex.code     = code_q;
    assign ex.axes     = axes_q;
    assign ex.data     = snap_q;

    // Class shortcuts of the executing command
    wire is_sync_w  = ex.cls == mcp_pkg::CLS_SYNC_EN ||
                      ex.cls == mcp_pkg::CLS_SYNC_DIS ||
                      ex.cls == mcp_pkg::CLS_SYNC_ACT;
    wire is_read_w  = ex.cls == mcp_pkg::CLS_READ;
    wire is_other_w = ex.cls == mcp_pkg::CLS_OTHER;
    wire rd_ax_w    = ~axes_q[0] & axes_q[1];

    // Read-back source, lowest selected axis
    assign rd_sel_w =
        (code_q == mcp_pkg::OP_RD_CURAC) ? cur_accel_in[rd_ax_w]    :
        (code_q == mcp_pkg::OP_RD_ACCEL) ? accel_rate_out[rd_ax_w]  :
        (code_q == mcp_pkg::OP_RD_SPEED) ? start_speed_out[rd_ax_w] :
                                           mcp_pkg::PARAM_RST;

    // Status word
    assign status_w = {11'h000, interp_decel_en_out, drive_hold_out,
                       status_page_out, bad_q, ~idle_w};

    // Register read selection, unmapped reads give zero
    assign rd_mux_w =
        (reg_addr_in == mcp_pkg::ADDR_CMD)    ? {6'h00, axes_q, code_q} :
        (reg_addr_in == mcp_pkg::ADDR_DLO)    ? data_low_word_q         :
        (reg_addr_in == mcp_pkg::ADDR_DHI)    ? data_high_word_q        :
        (reg_addr_in == mcp_pkg::ADDR_MODE3)  ? mode_word_three_q       :
        (reg_addr_in == mcp_pkg::ADDR_STATUS) ? status_w                :
        (reg_addr_in == mcp_pkg::ADDR_RDLO)   ? rd_lo_q                 :
        (reg_addr_in == mcp_pkg::ADDR_RDHI)   ? rd_hi_q                 :
                                                mcp_pkg::WORD_RST;

    // Command sequencer next state
    always_comb
    begin
        case (state_q)
            mcp_pkg::ST_IDLE: state_d = take_w ? mcp_pkg::ST_EXEC
                                               : mcp_pkg::ST_IDLE;
            mcp_pkg::ST_EXEC: state_d = mcp_pkg::ST_IDLE;
            default:          state_d = mcp_pkg::ST_IDLE;
        endcase
    end

    // Sequencer state
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            state_q <= mcp_pkg::ST_IDLE;
        else
            state_q <= state_d;
    end

    // Data and mode words
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            data_low_word_q   <= mcp_pkg::WORD_RST;
            data_high_word_q  <= mcp_pkg::WORD_RST;
            mode_word_three_q <= mcp_pkg::WORD_RST;
        end
        else
        begin
            if (wr_dlo_w)
                data_low_word_q <= reg_wdata_in;
            if (wr_dhi_w)
                data_high_word_q <= reg_wdata_in;
            if (wr_mode_w)
                mode_word_three_q <= reg_wdata_in;
        end
    end

    // Command capture with data snapshot
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            code_q <= 8'h00;
            axes_q <= 2'h0;
            snap_q <= mcp_pkg::PARAM_RST;
        end
        else if (take_w)
        begin
            code_q <= reg_wdata_in[mcp_pkg::CMDW_CODE_LSB +: 8];
            axes_q <= reg_wdata_in[mcp_pkg::CMDW_AXIS_LSB +: 2];
            snap_q <= {data_high_word_q, data_low_word_q};
        end
    end

    // Undefined code flag, set wins over clear
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            bad_q <= 1'b0;
        else if (exec_w && ex.cls == mcp_pkg::CLS_BAD)
            bad_q <= 1'b1;
        else if (wr_st_w && reg_wdata_in[mcp_pkg::ST_BAD_BIT])
            bad_q <= 1'b0;
    end

    // Decoded command strobe towards the drive logic
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cmd_stb_out   <= 1'b0;
            cmd_code_out  <= 8'h00;
            cmd_axes_out  <= 2'h0;
            cmd_class_out <= mcp_pkg::CLS_NONE;
        end
        else
        begin
            cmd_stb_out <= exec_w;
            if (exec_w)
            begin
                cmd_code_out  <= code_q;
                cmd_axes_out  <= axes_q;
                cmd_class_out <= ex.cls;
            end
        end
    end

    // Synchronous action selection from low nibble
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            sync_sel_out <= 4'h0;
        else if (exec_w && is_sync_w)
            sync_sel_out <= code_q[3:0];
    end

    // Persistent modes: status page, drive hold, interpolation decel
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            status_page_out     <= 1'b0;
            drive_hold_out      <= 1'b0;
            interp_decel_en_out <= 1'b0;
        end
        else if (exec_w)
        begin
            case (code_q)
                mcp_pkg::OP_PAGE0:   status_page_out <= 1'b0;
                mcp_pkg::OP_PAGE1:   status_page_out <= 1'b1;
                mcp_pkg::OP_HOLD:    drive_hold_out  <= 1'b1;
                mcp_pkg::OP_RELEASE: drive_hold_out  <= 1'b0;
                mcp_pkg::OP_DEC_EN:  interp_decel_en_out <= 1'b1;
                mcp_pkg::OP_DEC_DIS: interp_decel_en_out <= 1'b0;
                mcp_pkg::OP_CMD_RST:
                begin
                    status_page_out     <= is_other_w ? 1'b0 : status_page_out;
                    drive_hold_out      <= 1'b0;
                    interp_decel_en_out <= 1'b0;
                end
                default:             drive_hold_out <= drive_hold_out;
            endcase
        end
    end

    // Read command results
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rd_lo_q <= mcp_pkg::WORD_RST;
            rd_hi_q <= mcp_pkg::WORD_RST;
        end
        else if (exec_w && is_read_w)
        begin
            rd_lo_q <= rd_sel_w[15:0];
            rd_hi_q <= rd_sel_w[31:16];
        end
    end

    // Register read data, one cycle after the strobe only
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            reg_rdata_out <= mcp_pkg::WORD_RST;
        else
            reg_rdata_out <= reg_rd_in ? rd_mux_w : mcp_pkg::WORD_RST;
    end

    // Code classification
    mcp_cmd_decode u_decode (
        .dec_if (ex)
    );

    // One parameter store per axis
    generate
        for (genvar a = 0; a < 2; a++)
        begin : g_axis
            mcp_axis_params #(
                .AXIS (a)
            ) u_axis (
                .clock_in        (clock_in),
                .rst_in          (rst_in),
                .ex_if           (ex),
                .sym_sel_in      (sym_w),
                .jerk_value_out  (jerk_value_out[a]),
                .decel_jerk_out  (decel_jerk_value_out[a]),
                .accel_rate_out  (accel_rate_out[a]),
                .decel_rate_out  (decel_rate_out[a]),
                .start_speed_out (start_speed_out[a])
            );
        end
    endgenerate

    // Checks on the command path
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    accept_time_a : assert property (take_w |-> ##2 cmd_stb_out)
        else $error("command not executed in time");

    drive_class_a : assert property (
        exec_w && (code_q == 8'h50 || code_q == 8'h5A)
        |=> cmd_class_out == mcp_pkg::CLS_DRIVE)
        else $error("drive code misclassified");

    interp_class_a : assert property (
        exec_w && code_q == 8'h64 |=> cmd_class_out == mcp_pkg::CLS_INTERP)
        else $error("interpolation code misclassified");

    sync_sel_a : assert property (
        exec_w && code_q == 8'h93
        |=> sync_sel_out == 4'h3 && cmd_class_out == mcp_pkg::CLS_SYNC_DIS)
        else $error("sync selection wrong");

    other_class_a : assert property (
        exec_w && code_q == 8'h73 |=> cmd_class_out == mcp_pkg::CLS_OTHER)
        else $error("other code misclassified");

    page_select_a : assert property (
        exec_w && code_q == mcp_pkg::OP_PAGE1 |=> status_page_out)
        else $error("status page not selected");

    bad_flag_a : assert property (
        exec_w && ex.cls == mcp_pkg::CLS_BAD |=> bad_q)
        else $error("undefined code not flagged");

    multi_axis_a : assert property (
        exec_w && code_q == mcp_pkg::OP_ACCEL && axes_q == 2'h3
        |=> accel_rate_out[0] == $past(snap_q) &&
            accel_rate_out[1] == $past(snap_q))
        else $error("multi-axis load differs");

    jerk_load_a : assert property (
        exec_w && code_q == mcp_pkg::OP_JERK && axes_q[0]
        |=> jerk_value_out[0] == $past(snap_q))
        else $error("jerk not loaded");

    sym_jerk_a : assert property (
        $past(!sym_w) && $stable(jerk_value_out[1])
        |-> decel_jerk_value_out[1] == jerk_value_out[1])
        else $error("symmetric jerk not shared");

    sym_accel_a : assert property (
        $past(!sym_w) && $stable(accel_rate_out[0])
        |-> decel_rate_out[0] == accel_rate_out[0])
        else $error("symmetric decel not shared");

    speed_read_a : assert property (
        exec_w && code_q == mcp_pkg::OP_RD_SPEED && axes_q == 2'h1
        |=> {rd_hi_q, rd_lo_q} == $past(start_speed_out[0]))
        else $error("initial speed read-back wrong");

    data_snap_a : assert property (
        take_w |=> snap_q == $past({data_high_word_q, data_low_word_q})
                   ##1 $stable(snap_q))
        else $error("data not sampled at command");

    // Main scenarios
    cov_param_both_c : cover property (
        exec_w && ex.cls == mcp_pkg::CLS_PARAM && axes_q == 2'h3);
    cov_drive_c : cover property (exec_w && ex.cls == mcp_pkg::CLS_DRIVE);
    cov_read_c : cover property (exec_w && is_read_w ##[1:8] reg_rd_in);
    cov_b2b_c : cover property (take_w ##[2:16] take_w);

endmodule : mcp_cmd_core

// [mcp_host_model.sv]
// Host model driving the register port of the command block
`timescale 1ns/100ps
module mcp_host_model (
    input  wire logic        clock_in,
    output logic [2:0]       addr_out,
    output logic [15:0]      wdata_out,
    output logic             wr_out,
    output logic             rd_out,
    input  wire logic [15:0] rdata_in
);
    // Quiet bus from time zero
    initial
    begin
        addr_out  = 3'h0;
        wdata_out = 16'h0000;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
    end
    // One-cycle write strobe, then an idle cycle
    task wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clock_in);
        addr_out  <= a;
        wdata_out <= d;
        wr_out    <= 1'b1;
        @(posedge clock_in);
        wr_out    <= 1'b0;
    endtask : wr
    // Read strobe; data taken in the following cycle
    task rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge clock_in);
        addr_out <= a;
        rd_out   <= 1'b1;
        @(posedge clock_in);
        rd_out   <= 1'b0;
        @(posedge clock_in);
        d = rdata_in;
    endtask : rd
    // Data words, command word, then a spoiling data write
    task cmd(input logic [7:0] c, input logic [1:0] x, input logic [31:0] d);
        wr(3'h2, d[31:16]);
        wr(3'h1, d[15:0]);
        wr(3'h0, {6'h00, x, c});
        wr(3'h1, ~d[15:0]);
        repeat (2) @(posedge clock_in);
    endtask : cmd
endmodule : mcp_host_model

// [testbench.sv]
// Self-checking bench of the command decoder and parameter path
`timescale 1ns/100ps
module testbench;
    logic             clock_in, rst_in, wr, rd, page, hold, idec, sym, stb;
    logic [2:0]       addr;
    logic [15:0]      wdata, rdata, lo, hi;
    logic [1:0][31:0] cur_acc, jk, dj, ac, dc, sv;
    logic [7:0]       code, k;
    logic [3:0]       cls, ssel;
    logic [1:0]       x, ax;
    logic [31:0]      d;
    logic [31:0]      m [5][2];
    int               error_cnt = 0;
    int               tests_run = 0;
    int               stb_cnt = 0;
    int               n;

    mcp_host_model i_host (.clock_in(clock_in), .addr_out(addr),
        .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .rdata_in(rdata));
    mcp_cmd_core i_dut (.clock_in(clock_in), .rst_in(rst_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .cur_accel_in(cur_acc),
        .jerk_value_out(jk), .decel_jerk_value_out(dj),
        .accel_rate_out(ac), .decel_rate_out(dc), .start_speed_out(sv),
        .cmd_stb_out(stb), .cmd_code_out(code), .cmd_axes_out(ax),
        .cmd_class_out(cls), .sync_sel_out(ssel), .status_page_out(page),
        .drive_hold_out(hold), .interp_decel_en_out(idec));

    // Upper bound of each parameter's range
    function automatic logic [31:0] lim(input logic [7:0] k);
        return k < 2 ? 32'h3FFF_FFFF : k < 4 ? 32'h1FFF_FFFF : 32'h007A_1200;
    endfunction : lim
    // Expected class of a drive, interpolation, other or sync code; B marks any other code
    function automatic logic [3:0] cls_of(input logic [7:0] c);
        if (c >= 8'h50 && c <= 8'h5A && c != 8'h55) return 4'h4;
        if (c == 8'h61 || (c >= 8'h64 && c <= 8'h66)) return 4'h5;
        if (c >= 8'h6D && c <= 8'h6F) return 4'h5;
        if (c >= 8'h70 && c <= 8'h7C) return 4'h6;
        if (c[3:0] != 4'h0 && c[7:4] >= 4'h8 && c[7:4] <= 4'hA)
            return c[7:4] - 4'h1;
        return 4'hB;
    endfunction : cls_of
    // Compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Read both result words
    task rdchk(input logic [31:0] exp);
        i_host.rd(3'h5, lo);
        i_host.rd(3'h6, hi);
        chk({hi, lo}, exp);
    endtask : rdchk
    task give_verdict;
        $display("Errors %0d of %0d checks", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict

    // Clock, 50 ns period
    initial
    begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end
    // Hang guard
    initial
    begin
        repeat (6000) @(posedge clock_in);
        error_cnt++;
        give_verdict();
    end
    // Executed command strobes seen
    always @(posedge clock_in)
        if (stb === 1'b1) stb_cnt++;
    // Main sequence
    initial
    begin
        rst_in = 1'b1;
        void'($urandom(84998));
        cur_acc = {$urandom, $urandom};
        foreach (m[i, a]) m[i][a] = 32'h0;
        repeat (20) @(posedge clock_in);
        rst_in <= 1'b0;
        // Parameter writes: range ends first, then random
        for (int i = 0; i < 40; i++)
        begin
            k = i < 10 ? i % 5 : $urandom_range(4, 0);
            x = $urandom_range(3, 1);
            d = i < 5 ? lim(k) : i < 10 ? 32'h1 : $urandom_range(lim(k), 1);
            if (k == 4 && i >= 10 && d < 32'h5A83) d = 32'h5A83;
            sym = $urandom_range(1, 0);
            i_host.wr(3'h3, {14'h0000, sym, 1'b0});
            i_host.cmd(k, x, d);
            for (int a = 0; a < 2; a++)
            begin
                if (x[a]) m[k][a] = d;
                chk(jk[a], m[0][a]);
                chk(dj[a], sym ? m[1][a] : m[0][a]);
                chk(ac[a], m[2][a]);
                chk(dc[a], sym ? m[3][a] : m[2][a]);
                chk(sv[a], m[4][a]);
            end
        end
        i_host.cmd(8'h43, 2'h1, 32'h0);
        rdchk(m[2][0]);
        i_host.cmd(8'h44, 2'h2, 32'h0);
        rdchk(m[4][1]);
        i_host.cmd(8'h33, 2'h2, 32'h0);
        rdchk(cur_acc[1]);
        i_host.cmd(8'h30, 2'h1, 32'h0);
        rdchk(32'h0);
        chk(cls, 4'h3);
        // Every defined drive, interpolation, other and sync code
        for (int c = 8'h50; c < 8'hB0; c++)
        begin
            if (cls_of(c[7:0]) != 4'hB)
            begin
                n = stb_cnt;
                i_host.cmd(c[7:0], 2'h3, 32'h0);
                chk(stb_cnt, n + 1);
                chk(ax, 2'h3);
                chk(cls, cls_of(c[7:0]));
                chk(code, c);
                if (c >= 8'h81) chk(ssel, c[3:0]);
                if (c == 8'h77 || c == 8'h78) chk(hold, c == 8'h77);
                if (c == 8'h7A || c == 8'h7B) chk(page, c == 8'h7B);
                if (c == 8'h6D || c == 8'h6E) chk(idec, c == 8'h6D);
            end
        end
        // Command reset clears the persistent modes, then a no-operation
        i_host.cmd(8'h77, 2'h1, 32'h0);
        i_host.cmd(8'hFF, 2'h1, 32'h0);
        chk({cls, hold, page, idec}, 7'h30);
        i_host.cmd(8'h1F, 2'h1, 32'h0);
        chk(cls, 4'hA);
        give_verdict();
    end
endmodule : testbench
